// [pkg/osr_pkg.sv]
// Constants, field layouts and carrier types of the output and vector router
package osr_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int OSR_LINES = 12;
	localparam int OSR_TIMERS = 8;
	localparam int OSR_VECTORS = 16;
	localparam int OSR_VSRC_EDGE = 8;
	localparam int OSR_VSRC_CHAIN = 20;
	localparam int OSR_VSRC_GPS = 32;
	localparam int OSR_VSRC_IRIG = 33;
	localparam int OSR_NUM_VSRC = 34;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OSR_OFF_GEN = 12'h000;
	localparam logic [11:0] OSR_OFF_GEN_SET = 12'h004;
	localparam logic [11:0] OSR_OFF_GEN_CLR = 12'h008;
	localparam logic [11:0] OSR_OFF_PIN_DIR = 12'h00c;
	localparam logic [11:0] OSR_OFF_VEC_CMD = 12'h010;
	localparam logic [11:0] OSR_OFF_VEC_LOOK = 12'h014;
	localparam logic [11:0] OSR_OFF_IRQ_STATUS = 12'h018;
	localparam logic [11:0] OSR_OFF_IRQ_CLEAR = 12'h01c;
	localparam logic [11:0] OSR_OFF_IRQ_ENABLE = 12'h020;
	localparam logic [11:0] OSR_OFF_OUT_LEVEL = 12'h024;
	localparam logic [5:0] OSR_OFF_CFG_PAGE = 6'h01;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OSR_CFG_SRC_LSB = 0;
	localparam int OSR_CFG_INV_BIT = 8;
	localparam int OSR_VCMD_SRC_LSB = 0;
	localparam int OSR_VCMD_VEC_LSB = 8;
	localparam int OSR_VCMD_NONE_BIT = 16;
	localparam int OSR_VLOOK_VEC_LSB = 8;
	localparam int OSR_IRQ_REJECT = 0;
	localparam int OSR_IRQ_BADVEC = 1;
	localparam int OSR_IRQ_BITS = 2;
	// ----------------------------------------------------------------
	// Output source codes
	// ----------------------------------------------------------------
	localparam logic [5:0] OSR_SRC_TIMER = 6'h00;
	localparam logic [5:0] OSR_SRC_GEN = 6'h08;
	localparam logic [5:0] OSR_SRC_EDGE = 6'h14;
	localparam logic [5:0] OSR_SRC_CHAIN = 6'h20;
	localparam logic [5:0] OSR_SRC_LAST = 6'h30;
	localparam logic [5:0] OSR_SRC_NONE = 6'h3f;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [11:0] OSR_RST_GEN = 12'h000;
	localparam logic [11:0] OSR_RST_PIN_DIR = 12'hfff;
	localparam logic [1:0] OSR_RST_IRQ_ENABLE = 2'h0;
	localparam int OSR_RST_TIMER_VEC = 1;
	localparam int OSR_RST_EDGE_FIRST = 6;
	localparam int OSR_RST_EDGE_VEC = 9;
	localparam logic [3:0] OSR_RST_CHAIN_VEC = 4'hf;
	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic invert;
		logic [5:0] src;
	} osr_out_cfg_type;
	typedef struct packed {
		logic master_time;
		logic ten_megahertz_reference;
		logic time_code;
		logic irig_pps;
		logic gps_pps;
	} osr_refs_type;
	// Vector that a source takes at reset
	function automatic logic [3:0] osr_reset_vector(input int s);
		if (s < OSR_TIMERS) begin
			return 4'(s + OSR_RST_TIMER_VEC);
		end
		if (s >= OSR_VSRC_EDGE + OSR_RST_EDGE_FIRST && s < OSR_VSRC_CHAIN) begin
			return 4'(s - OSR_VSRC_EDGE - OSR_RST_EDGE_FIRST + OSR_RST_EDGE_VEC);
		end
		if (s == OSR_VSRC_CHAIN) begin
			return OSR_RST_CHAIN_VEC;
		end
		return 4'h0;
	endfunction
endpackage

// [src/osr_router.sv]
// Output line source router and message vector router with APB registers
// What this block does
// - Twelve external output lines, numbered 0 to 11
// - Per-line selector: timer, generator, edge, chain, pps
// - Selector also offers time code, ten_megahertz_reference, master time
// - No-source selection floats the line
// - Reset: line N follows generator bit N
// - Reject pin input driving own pin
// - Pin drives only when set as output
// - Per-line polarity invert, default by variant
// - Sixteen message vectors, independently attached
// - Vector selector sources; none empties vector
// - Reset: timers 0-7 on vectors 1-8
// - Reset: edges 6-11 on 9-14, chain0 on 15
// - Vector 0 catches all unassociated sources
// - Associating with vector 0 drops old vector
// - Orphaned sources fall back to vector 0
// - Twelve generator bits in one register
module osr_router #(
	parameter bit OLDER_VARIANT = 1'b0
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Internal sources and external references
	input wire logic [osr_pkg::OSR_TIMERS-1:0] timer_event,
	input wire logic [osr_pkg::OSR_LINES-1:0] chain_shared_interrupt,
	input wire osr_pkg::osr_refs_type refs,
	// Bidirectional external pins
	input wire logic [osr_pkg::OSR_LINES-1:0] bidirectional_external_pin_level,
	output logic [osr_pkg::OSR_LINES-1:0] external_output_line,
	output logic [osr_pkg::OSR_LINES-1:0] external_output_line_enable,
	// Message vector requests and interrupt
	output logic [osr_pkg::OSR_VECTORS-1:0] message_vector_slot_request,
	output logic irq
);
	import osr_pkg::*;

	localparam int EXT_W = $bits(osr_refs_type) + 2 * OSR_LINES;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [11:0] software_driven_generator_bit;
	logic [11:0] pin_dir;
	osr_out_cfg_type out_cfg [OSR_LINES];
	logic [3:0] vec_tab [OSR_NUM_VSRC];
	logic [5:0] look_idx;
	logic [OSR_IRQ_BITS-1:0] irq_status;
	logic [OSR_IRQ_BITS-1:0] irq_enable;
	logic [EXT_W-1:0] sync1;
	logic [EXT_W-1:0] sync2;
	logic [EXT_W-1:0] sync3;
	logic [EXT_W-1:0] ext_f;
	logic [OSR_NUM_VSRC-1:0] vsrc_prev;
	logic after_reset;

	// ----------------------------------------------------------------
	// External input conditioning
	// ----------------------------------------------------------------
	// Three stages; a bit changes only once stages two and three agree,
	// which rejects single-cycle glitches on slow pins
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			ext_f <= '0;
		end else begin
			sync1 <= {refs, chain_shared_interrupt, bidirectional_external_pin_level};
			sync2 <= sync1;
			sync3 <= sync2;
			ext_f <= (sync3 & ~(sync2 ^ sync3)) | (ext_f & (sync2 ^ sync3));
		end
	end

	logic [OSR_LINES-1:0] external_edge_input;
	logic [OSR_LINES-1:0] chain_f;
	osr_refs_type refs_f;
	assign external_edge_input = ext_f[OSR_LINES-1:0];
	assign chain_f = ext_f[2*OSR_LINES-1:OSR_LINES];
	assign refs_f = osr_refs_type'(ext_f[EXT_W-1:2*OSR_LINES]);

	// Selectable levels, indexed by source code; unused codes read low
	logic [63:0] out_pool;
	assign out_pool = {15'h0000, refs_f, chain_f, external_edge_input,
		software_driven_generator_bit, timer_event};

	// Vector source levels, indexed by vector source number
	logic [OSR_NUM_VSRC-1:0] vsrc_level;
	assign vsrc_level = {refs_f.irig_pps, refs_f.gps_pps, chain_f, external_edge_input, timer_event};

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic setup;
	logic access;
	logic cfg_hit;
	logic [3:0] cfg_idx;
	logic [5:0] new_src;
	logic cfg_reject;
	logic self_loop;
	logic [5:0] cmd_src;
	logic [3:0] cmd_vec;
	logic cmd_none;
	logic bad_vec;
	logic mapped;
	logic [31:0] next_rdata;

	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign cfg_idx = paddr[5:2];
	assign cfg_hit = (paddr[11:6] == OSR_OFF_CFG_PAGE) && (paddr[1:0] == 2'h0) && (cfg_idx < 4'(OSR_LINES));
	assign new_src = pwdata[OSR_CFG_SRC_LSB +: 6];
	assign self_loop = (new_src == OSR_SRC_EDGE + 6'(cfg_idx));
	assign cfg_reject = cfg_hit & (self_loop | (new_src > OSR_SRC_LAST && new_src != OSR_SRC_NONE));
	assign cmd_src = pwdata[OSR_VCMD_SRC_LSB +: 6];
	assign cmd_vec = pwdata[OSR_VCMD_VEC_LSB +: 4];
	assign cmd_none = pwdata[OSR_VCMD_NONE_BIT];
	assign bad_vec = (paddr == OSR_OFF_VEC_CMD) & ~cmd_none & (cmd_src >= 6'(OSR_NUM_VSRC));

	// Read mux; write-only registers read as zero
	always_comb begin
		next_rdata = 32'h00000000;
		mapped = 1'b1;
		case (paddr)
			OSR_OFF_GEN: next_rdata[11:0] = software_driven_generator_bit;
			OSR_OFF_PIN_DIR: next_rdata[11:0] = pin_dir;
			OSR_OFF_VEC_LOOK: begin
				next_rdata[5:0] = look_idx;
				if (look_idx < 6'(OSR_NUM_VSRC)) begin
					next_rdata[OSR_VLOOK_VEC_LSB +: 4] = vec_tab[look_idx];
				end
			end
			OSR_OFF_IRQ_STATUS: next_rdata[OSR_IRQ_BITS-1:0] = irq_status;
			OSR_OFF_IRQ_ENABLE: next_rdata[OSR_IRQ_BITS-1:0] = irq_enable;
			OSR_OFF_OUT_LEVEL: next_rdata[11:0] = external_output_line;
			OSR_OFF_GEN_SET, OSR_OFF_GEN_CLR, OSR_OFF_VEC_CMD, OSR_OFF_IRQ_CLEAR: next_rdata = 32'h00000000;
			default: begin
				if (cfg_hit) begin
					next_rdata[OSR_CFG_SRC_LSB +: 6] = out_cfg[cfg_idx].src;
					next_rdata[OSR_CFG_INV_BIT] = out_cfg[cfg_idx].invert;
				end else begin
					mapped = 1'b0;
				end
			end
		endcase
	end

	// Zero-wait answer: pready rises in the first access cycle
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup & (~mapped | (pwrite & (cfg_reject | bad_vec)));
			prdata <= (setup & ~pwrite) ? next_rdata : 32'h00000000;
		end
	end

	logic wr;
	logic rej_evt;
	logic badvec_evt;
	assign wr = access & pwrite & ~pslverr;
	assign rej_evt = access & pwrite & cfg_hit & cfg_reject;
	assign badvec_evt = access & pwrite & bad_vec;

	// ----------------------------------------------------------------
	// Generator bits and pin direction
	// ----------------------------------------------------------------
	// Set and clear words let several masters touch bits without a race
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			software_driven_generator_bit <= OSR_RST_GEN;
		end else if (wr && paddr == OSR_OFF_GEN) begin
			software_driven_generator_bit <= pwdata[11:0];
		end else if (wr && paddr == OSR_OFF_GEN_SET) begin
			software_driven_generator_bit <= software_driven_generator_bit | pwdata[11:0];
		end else if (wr && paddr == OSR_OFF_GEN_CLR) begin
			software_driven_generator_bit <= software_driven_generator_bit & ~pwdata[11:0];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pin_dir <= OSR_RST_PIN_DIR;
		end else if (wr && paddr == OSR_OFF_PIN_DIR) begin
			pin_dir <= pwdata[11:0];
		end
	end

	// ----------------------------------------------------------------
	// Output selectors and pin drive
	// ----------------------------------------------------------------
	// Only the addressed line is written; a rejected write never lands
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int n = 0; n < OSR_LINES; n++) begin
				out_cfg[n].src <= OSR_SRC_GEN + 6'(n);
				out_cfg[n].invert <= OLDER_VARIANT;
			end
		end else if (wr && cfg_hit) begin
			out_cfg[cfg_idx].src <= new_src;
			out_cfg[cfg_idx].invert <= pwdata[OSR_CFG_INV_BIT];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			external_output_line <= '0;
			external_output_line_enable <= '0;
		end else begin
			for (int n = 0; n < OSR_LINES; n++) begin
				external_output_line[n] <= out_pool[out_cfg[n].src] ^ out_cfg[n].invert;
				external_output_line_enable[n] <= pin_dir[n] & (out_cfg[n].src != OSR_SRC_NONE);
			end
		end
	end

	// ----------------------------------------------------------------
	// Vector association table
	// ----------------------------------------------------------------
	// One vector per source, so a source can never sit on two vectors
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int s = 0; s < OSR_NUM_VSRC; s++) begin
				vec_tab[s] <= osr_reset_vector(s);
			end
		end else if (wr && paddr == OSR_OFF_VEC_CMD) begin
			if (cmd_none) begin
				for (int s = 0; s < OSR_NUM_VSRC; s++) begin
					if (vec_tab[s] == cmd_vec) begin
						vec_tab[s] <= 4'h0;
					end
				end
			end else begin
				vec_tab[cmd_src] <= cmd_vec;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			look_idx <= 6'h00;
		end else if (wr && paddr == OSR_OFF_VEC_LOOK) begin
			look_idx <= pwdata[5:0];
		end
	end

	// ----------------------------------------------------------------
	// Vector requests
	// ----------------------------------------------------------------
	logic [OSR_NUM_VSRC-1:0] vsrc_rise;
	logic [OSR_VECTORS-1:0] next_request;
	assign vsrc_rise = vsrc_level & ~vsrc_prev;

	// A rising source raises only its own vector; vector 0 collects the rest
	always_comb begin
		next_request = '0;
		for (int s = 0; s < OSR_NUM_VSRC; s++) begin
			if (vsrc_rise[s]) begin
				next_request[vec_tab[s]] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			vsrc_prev <= '0;
			message_vector_slot_request <= '0;
		end else begin
			vsrc_prev <= vsrc_level;
			message_vector_slot_request <= next_request;
		end
	end

	// ----------------------------------------------------------------
	// Error status and interrupt
	// ----------------------------------------------------------------
	logic [OSR_IRQ_BITS-1:0] status_set;
	logic [OSR_IRQ_BITS-1:0] status_clr;
	assign status_set = {badvec_evt, rej_evt};
	assign status_clr = (wr && paddr == OSR_OFF_IRQ_CLEAR) ? pwdata[OSR_IRQ_BITS-1:0] : '0;

	// A new event beats a clear landing in the same cycle
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~status_clr) | status_set;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq_enable <= OSR_RST_IRQ_ENABLE;
		end else if (wr && paddr == OSR_OFF_IRQ_ENABLE) begin
			irq_enable <= pwdata[OSR_IRQ_BITS-1:0];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Marks the first edge after reset release
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			after_reset <= 1'b1;
		end else begin
			after_reset <= 1'b0;
		end
	end

	genvar g;
	for (g = 0; g < OSR_LINES; g++) begin : g_line_chk
		a_line_float:
		assert property (@(posedge clk_sys) disable iff (reset)
			(out_cfg[g].src == OSR_SRC_NONE) |=> !external_output_line_enable[g])
		else $error("line driven with no source");
		a_dir_gate:
		assert property (@(posedge clk_sys) disable iff (reset)
			!pin_dir[g] |=> !external_output_line_enable[g])
		else $error("input pin driven");
		a_gen_polarity:
		assert property (@(posedge clk_sys) disable iff (reset)
			(out_cfg[g].src == OSR_SRC_GEN + 6'(g)) |=>
			external_output_line[g] == ($past(software_driven_generator_bit[g]) ^ $past(out_cfg[g].invert)))
		else $error("generator level wrong on line");
		a_reject_keep:
		assert property (@(posedge clk_sys) disable iff (reset)
			(rej_evt && cfg_idx == 4'(g)) |=> $stable(out_cfg[g]) && irq_status[OSR_IRQ_REJECT])
		else $error("rejected selection landed");
	end

	a_reset_map:
	assert property (@(posedge clk_sys) disable iff (reset)
		after_reset |-> vec_tab[0] == 4'h1 && vec_tab[7] == 4'h8 && vec_tab[14] == 4'h9
		&& vec_tab[19] == 4'he && vec_tab[20] == 4'hf && vec_tab[8] == 4'h0)
	else $error("reset vector map wrong");

	a_assoc_move:
	assert property (@(posedge clk_sys) disable iff (reset)
		(wr && paddr == OSR_OFF_VEC_CMD && !cmd_none) |=> vec_tab[$past(cmd_src)] == $past(cmd_vec))
	else $error("association not taken");

	a_none_empty:
	assert property (@(posedge clk_sys) disable iff (reset)
		(wr && paddr == OSR_OFF_VEC_CMD && cmd_none && cmd_vec == 4'h1 && vec_tab[0] == 4'h1)
		|=> vec_tab[0] == 4'h0)
	else $error("orphan not moved to vector 0");

	a_gps_route:
	assert property (@(posedge clk_sys) disable iff (reset)
		vsrc_rise[OSR_VSRC_GPS] |=> message_vector_slot_request[$past(vec_tab[OSR_VSRC_GPS])])
	else $error("event missed its vector");

	a_gen_set:
	assert property (@(posedge clk_sys) disable iff (reset)
		(wr && paddr == OSR_OFF_GEN_SET) |=>
		software_driven_generator_bit == ($past(software_driven_generator_bit) | $past(pwdata[11:0])))
	else $error("generator set failed");

	a_apb_answer:
	assert property (@(posedge clk_sys) disable iff (reset)
		setup |=> pready ##1 !pready)
	else $error("apb answer timing");
endmodule // osr_router

// [tb/osr_far_side.sv]
// Model of the external equipment standing on the bidirectional pins
module osr_far_side (
	// Block side of the pins
	input wire logic [osr_pkg::OSR_LINES-1:0] drive_level,
	input wire logic [osr_pkg::OSR_LINES-1:0] drive_enable,
	// Equipment side of the pins
	input wire logic [osr_pkg::OSR_LINES-1:0] equip_level,
	output logic [osr_pkg::OSR_LINES-1:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	import osr_pkg::*;
	// ----------------------------------------------------------------
	// Wire resolution
	// ----------------------------------------------------------------
	// The equipment drives a pin only while the block has released it, so no contention is modelled
	always_comb begin
		for (int n = 0; n < OSR_LINES; n++) begin
			pin_level[n] = drive_enable[n] ? drive_level[n] : equip_level[n];
		end
	end
endmodule // osr_far_side

// [tb/output_and_msix_source_router_bench.sv]
// Self-checking bench of the output line and message vector router
`define CHK(got, exp) check(32'(got), 32'(exp))
module output_and_msix_source_router_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import osr_pkg::*;
	// ----------------------------------------------------------------
	// Signals and reference model state
	// ----------------------------------------------------------------
	logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [11:0] paddr, chain, pin_level, line, line_en, equip, gen, dir;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] timer_event;
	logic [15:0] vreq, seen;
	osr_refs_type refs;
	logic [5:0] osrc[OSR_LINES];
	logic inv[OSR_LINES];
	int bad_count, n_compared, v;
	int vmap[OSR_NUM_VSRC];
	// Clock at 250 MHz
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	osr_router dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_event(timer_event), .chain_shared_interrupt(chain), .refs(refs),
		.bidirectional_external_pin_level(pin_level), .external_output_line(line),
		.external_output_line_enable(line_en), .message_vector_slot_request(vreq), .irq(irq));
	osr_far_side equipment (.drive_level(line), .drive_enable(line_en), .equip_level(equip),
		.pin_level(pin_level));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; read data and error are taken at the pready edge only
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			bad_count++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic set_line(input int n, input logic [5:0] s, input logic iv);
		osrc[n] = s;
		inv[n] = iv;
		apb(1'b1, 12'h040 + 12'(4 * n), {23'h0, iv, 2'h0, s});
	endtask
	function automatic logic exp_bit(input logic [5:0] s);
		if (s < 8) return timer_event[s];
		if (s >= 8 && s < 20) return gen[s - 8];
		if (s >= 20 && s < 32) return pin_level[s - 20];
		if (s >= 32 && s < 44) return chain[s - 32];
		if (s >= 44 && s <= 48) return refs[s - 44];
		return 1'b0;
	endfunction
	// Compare every line enable with the model, and each enabled line and its level register bit
	task automatic check_lines();
		repeat (8) @(posedge clk_sys);
		for (int n = 0; n < OSR_LINES; n++) begin
			`CHK(line_en[n], dir[n] && osrc[n] != 6'h3f);
			if (line_en[n]) `CHK(line[n], exp_bit(osrc[n]) ^ inv[n]);
		end
		apb(1'b0, OSR_OFF_OUT_LEVEL, 32'h0);
		for (int n = 0; n < OSR_LINES; n++) begin
			if (line_en[n]) `CHK(rd[n], exp_bit(osrc[n]) ^ inv[n]);
		end
	endtask
	// Raise one vector source, collect every vector pulse, then let it fall and settle
	task automatic fire(input int s);
		seen = '0;
		@(posedge clk_sys);
		if (s < 8) timer_event[s] <= 1'b1;
		else if (s < 20) equip[s - 8] <= 1'b1;
		else chain[s - 20] <= 1'b1;
		repeat (12) begin
			@(posedge clk_sys);
			seen = seen | vreq;
		end
		timer_event <= '0;
		equip <= '0;
		chain <= '0;
		repeat (12) @(posedge clk_sys);
		`CHK(seen, 16'h1 << vmap[s]);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{timer_event, chain, equip, refs} = '0;
		reset = 1'b1;
		void'($urandom(15));
		gen = '0;
		dir = 12'hfff;
		for (int n = 0; n < OSR_LINES; n++) begin
			osrc[n] = 6'(8 + n);
			inv[n] = 1'b0;
		end
		for (int s = 0; s < OSR_NUM_VSRC; s++) begin
			vmap[s] = (s < 8) ? s + 1 : (s >= 14 && s < 20) ? s - 5 : (s == 20) ? 15 : 0;
		end
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		// Reset values and default routing
		apb(1'b0, OSR_OFF_GEN, 32'h0);
		`CHK(rd, 32'h0);
		apb(1'b0, OSR_OFF_PIN_DIR, 32'h0);
		`CHK(rd, 32'hfff);
		apb(1'b0, OSR_OFF_IRQ_ENABLE, 32'h0);
		`CHK(rd, 32'h0);
		for (int n = 0; n < OSR_LINES; n++) begin
			apb(1'b0, 12'h040 + 12'(4 * n), 32'h0);
			`CHK(rd, 8 + n);
		end
		check_lines();
		$display("test reset done");
		// Generator register with set and clear words
		gen = 12'($urandom);
		apb(1'b1, OSR_OFF_GEN, {20'h0, gen});
		check_lines();
		gen = gen | 12'h008;
		apb(1'b1, OSR_OFF_GEN_SET, 32'h8);
		gen = gen & ~12'h001;
		apb(1'b1, OSR_OFF_GEN_CLR, 32'h1);
		check_lines();
		$display("test generator done");
		// Every reference code and timer codes 0 to 4, with polarity alternating
		for (int k = 0; k < 5; k++) begin
			refs <= osr_refs_type'(5'h1 << k);
			timer_event <= 8'h1 << k;
			set_line(0, 6'(44 + k), k[0]);
			set_line(1, 6'(k), ~k[0]);
			check_lines();
		end
		timer_event <= '0;
		$display("test sources done");
		// Float, direction and refused selections
		set_line(2, 6'h3f, 1'b0);
		dir = 12'hfff ^ 12'h050;
		apb(1'b1, OSR_OFF_PIN_DIR, {20'h0, dir});
		equip <= 12'($urandom);
		chain <= 12'($urandom);
		// Line 3 follows input pin 4, line 7 follows chain line 5
		set_line(3, 6'h18, 1'b1);
		set_line(7, 6'h25, 1'b0);
		check_lines();
		apb(1'b1, 12'h054, 32'h19);
		`CHK(err, 1'b1);
		apb(1'b1, 12'h054, 32'h31);
		`CHK(err, 1'b1);
		apb(1'b0, 12'h054, 32'h0);
		`CHK(rd, 32'hd);
		apb(1'b0, OSR_OFF_IRQ_STATUS, 32'h0);
		`CHK(rd, 32'h1);
		repeat (3) @(posedge clk_sys);
		`CHK(irq, 1'b0);
		apb(1'b1, OSR_OFF_IRQ_ENABLE, 32'h1);
		repeat (3) @(posedge clk_sys);
		`CHK(irq, 1'b1);
		apb(1'b1, OSR_OFF_IRQ_CLEAR, 32'h1);
		repeat (3) @(posedge clk_sys);
		`CHK(irq, 1'b0);
		apb(1'b0, 12'h0fc, 32'h0);
		`CHK(err, 1'b1);
		check_lines();
		$display("test refusal done");
		// Default vector routing, then random associations; pin echoes settle first
		equip <= '0;
		chain <= '0;
		repeat (24) @(posedge clk_sys);
		for (int s = 0; s < 8; s++) fire(s);
		fire(20);
		fire(14);
		fire(21);
		// Emptying vector 1 sends timer 0 back to vector 0
		apb(1'b1, OSR_OFF_VEC_CMD, 32'h10100);
		vmap[0] = 0;
		fire(0);
		for (int s = 0; s < 8; s++) begin
			v = $urandom_range(15, 0);
			vmap[s] = v;
			apb(1'b1, OSR_OFF_VEC_CMD, 32'(v << 8) | 32'(s));
		end
		for (int s = 0; s < 8; s++) fire(s);
		v = vmap[2];
		apb(1'b1, OSR_OFF_VEC_CMD, 32'h10000 | 32'(v << 8));
		for (int s = 0; s < OSR_NUM_VSRC; s++) begin
			if (vmap[s] == v) vmap[s] = 0;
		end
		for (int s = 0; s < 8; s++) fire(s);
		apb(1'b1, OSR_OFF_VEC_LOOK, 32'h3);
		apb(1'b0, OSR_OFF_VEC_LOOK, 32'h0);
		`CHK(rd, 32'(vmap[3] << 8) | 32'h3);
		apb(1'b1, OSR_OFF_VEC_CMD, 32'h522);
		`CHK(err, 1'b1);
		apb(1'b0, OSR_OFF_IRQ_STATUS, 32'h0);
		`CHK(rd, 32'h2);
		$display("test vectors done");
		wrap_up();
	end
endmodule // output_and_msix_source_router_bench
